// >>> design/sdadc_defines.svh
/*
 * constants of the two-wire converter port: widths, word codes, timings.
 * assumes a 100 MHz core clock; included by bare name, definitions only.
 */
`ifndef SDADC_DEFINES_SVH
`define SDADC_DEFINES_SVH

// word layout
`define SDADC_FULL_BITS      16
`define SDADC_RED_MAX        6
`define SDADC_WORD_RESERVED  16'h8000
`define SDADC_WORD_NEG_FS    16'h8001

// clock rates
`define SDADC_CORE_HZ        100000000
`define SDADC_OSC_HZ         520000
`define SDADC_OSC_DIV        (`SDADC_CORE_HZ / `SDADC_OSC_HZ)

// full conversion time in ms, window as full time * 10 / 857
`define SDADC_CONV_TIME_MS   125
`define SDADC_CONV_TICKS     (`SDADC_CONV_TIME_MS * `SDADC_OSC_HZ / 1000)
`define SDADC_WIN_TICKS      (`SDADC_CONV_TICKS * 10 / 857)

// clock line glitch filter: least accepted width, rounded up
`define SDADC_GLITCH_NS      50
`define SDADC_CORE_NS        10
`define SDADC_FILT_CYCLES    \
  ((`SDADC_GLITCH_NS + `SDADC_CORE_NS - 1) / `SDADC_CORE_NS)

`endif

// >>> design/sdadc_pkg.sv
/*
 * types of the two-wire converter port.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package sdadc_pkg;

  // conversion sequencer states
  typedef enum logic [1:0] {
    ST_SLEEP,
    ST_CONVERT,
    ST_READOUT
  } conv_state_t;

endpackage

// >>> design/sigma_delta_adc_two_wire_port.sv
/*
 * control and two-wire serial port of a 16-bit sigma-delta converter.
 * assumes the host drives the serial clock pin asynchronously, the analog
 * modulator delivers a 16-bit two's-complement word on i_conv_word, and
 * the internal oscillator is modelled as a divided tick of i_core_clk.
 */
`timescale 1ns/1ps
`include "sdadc_defines.svh"

module sigma_delta_adc_two_wire_port #(
  parameter int OSC_DIV     = `SDADC_OSC_DIV,
  parameter int CONV_TICKS  = `SDADC_CONV_TICKS,
  parameter int WIN_TICKS   = `SDADC_WIN_TICKS,
  parameter int FILT_CYCLES = `SDADC_FILT_CYCLES,
  parameter int TICK_W      = 17
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_serial_clk,
  input  wire logic [15:0] i_conv_word,
  output logic             o_serial_result_out,
  output logic             o_osc_run,
  output logic [2:0]       o_reduction
);

  // checks run on the core clock and rest during reset
  default clocking core_cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  // refuse settings the counters cannot hold; filter needs 5 samples
  if (OSC_DIV < 1 || OSC_DIV > 65536 || FILT_CYCLES < 5 ||
      FILT_CYCLES > 255 || CONV_TICKS >= (1 << TICK_W) ||
      (CONV_TICKS >> `SDADC_RED_MAX) <= WIN_TICKS)
  begin : g_bad_params
    $error("sigma_delta_adc_two_wire_port: bad parameters");
  end

  // clock line synchroniser, glitch filter and edge detect
  logic       sclk_s1_r;
  logic       sclk_s2_r;
  logic       filt_r;
  logic [7:0] filt_cnt_r;
  wire        differ_w  = (sclk_s2_r != filt_r);
  wire        change_w  = differ_w && (filt_cnt_r == 8'(FILT_CYCLES - 1));
  wire        fall_w    = change_w && filt_r;
  wire        rise_w    = change_w && !filt_r;

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      sclk_s1_r  <= 1'b1;
      sclk_s2_r  <= 1'b1;
      filt_r     <= 1'b1;
      filt_cnt_r <= 8'h00;
    end
    else
    begin
      sclk_s1_r  <= i_serial_clk;
      sclk_s2_r  <= sclk_s1_r;
      // a level must persist FILT_CYCLES samples to be taken
      filt_r     <= change_w ? sclk_s2_r : filt_r;
      filt_cnt_r <= (differ_w && !change_w) ? filt_cnt_r + 8'h01 : 8'h00;
    end
  end

  // sequencer state
  sdadc_pkg::conv_state_t state_r;
  logic [2:0]          red_r;
  logic                ack_r;
  logic                out_r;
  logic                osc_run_r;
  logic [15:0]         word_r;
  logic [4:0]          bit_cnt_r;
  logic [15:0]         div_cnt_r;
  logic [TICK_W-1:0]   tick_cnt_r;

  // oscillator tick and timing decode
  wire tick_w     = osc_run_r && (div_cnt_r == 16'(OSC_DIV - 1));
  wire win_open_w = (tick_cnt_r < TICK_W'(WIN_TICKS));
  wire [TICK_W-1:0] conv_len_w = TICK_W'(CONV_TICKS) >> red_r;
  wire conv_w     = (state_r == sdadc_pkg::ST_CONVERT);
  wire done_w     = conv_w && (tick_cnt_r >= conv_len_w);
  wire [4:0] nbits_w = 5'(`SDADC_FULL_BITS) - {2'b00, red_r};

  // edge classification
  wire start_w  = fall_w && ((state_r == sdadc_pkg::ST_SLEEP) ||
                  (state_r == sdadc_pkg::ST_READOUT &&
                   bit_cnt_r == nbits_w));
  wire reduce_w = fall_w && conv_w && win_open_w &&
                  (red_r < 3'(`SDADC_RED_MAX));
  wire shift_w  = fall_w && (state_r == sdadc_pkg::ST_READOUT) &&
                  (bit_cnt_r != nbits_w);
  wire ack_end_w = rise_w || !win_open_w;

  // reserved code folds onto negative full scale
  function automatic logic [15:0] fold_word(input logic [15:0] w);
    fold_word = (w == `SDADC_WORD_RESERVED) ? `SDADC_WORD_NEG_FS : w;
  endfunction

  // oscillator divider and tick counter, running only while converting
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst || !osc_run_r || tick_w)
      div_cnt_r <= 16'h0000;
    else
      div_cnt_r <= div_cnt_r + 16'h0001;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst || start_w)
      tick_cnt_r <= '0;
    else if (tick_w)
      tick_cnt_r <= tick_cnt_r + TICK_W'(1);
  end

  // conversion sequencer
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      state_r   <= sdadc_pkg::ST_SLEEP;
      osc_run_r <= 1'b0;
      red_r     <= 3'h0;
      bit_cnt_r <= 5'h00;
    end
    else if (start_w)
    begin
      state_r   <= sdadc_pkg::ST_CONVERT;
      osc_run_r <= 1'b1;
      red_r     <= 3'h0;
      bit_cnt_r <= 5'h00;
    end
    else if (done_w)
    begin
      state_r   <= sdadc_pkg::ST_READOUT;
      osc_run_r <= 1'b0;
    end
    else
    begin
      if (reduce_w)
        red_r <= red_r + 3'h1;
      if (shift_w)
        bit_cnt_r <= bit_cnt_r + 5'h01;
    end
  end

  // acknowledge flag: raised by start or reduction, dropped on rise/window
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      ack_r <= 1'b0;
    else if (start_w || reduce_w)
      ack_r <= 1'b1;
    else if (ack_end_w || !conv_w)
      ack_r <= 1'b0;
  end

  // result word capture and shifting, sign first
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      word_r <= 16'h0000;
    else if (done_w)
      word_r <= fold_word(i_conv_word);
    else if (shift_w)
      word_r <= {word_r[14:0], 1'b0};
  end

  // data pin: high asleep, ack/busy while converting, bits in readout
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      out_r <= 1'b1;
    else if (start_w || reduce_w)
      out_r <= 1'b1;
    else if (done_w)
      out_r <= 1'b1;
    else if (conv_w)
      out_r <= ack_r && !ack_end_w;
    else if (shift_w)
      out_r <= word_r[15];
  end

  assign o_serial_result_out = out_r;
  assign o_osc_run           = osc_run_r;
  assign o_reduction         = red_r;

  // checks
  sequence s_start_edge;
    (state_r == sdadc_pkg::ST_SLEEP) && fall_w;
  endsequence

  sequence s_ack_drop;
    conv_w && ack_r && rise_w && !reduce_w && !start_w;
  endsequence

  a_sleep_high: assert property (
    state_r == sdadc_pkg::ST_SLEEP |-> out_r && !osc_run_r)
    else $error("data not high while asleep");

  a_start_osc: assert property (
    s_start_edge |=> conv_w && osc_run_r && out_r && red_r == 3'h0)
    else $error("start edge did not start conversion");

  a_reduce_step: assert property (
    reduce_w |=> red_r == $past(red_r) + 3'h1 && out_r)
    else $error("reduction not taken or not acknowledged");

  a_reduce_floor: assert property (
    conv_w && fall_w && red_r == 3'h6 |=> red_r == 3'h6)
    else $error("resolution below ten bits");

  a_reduce_limit: assert property (
    red_r <= 3'h6)
    else $error("reduction count beyond six");

  a_ack_drop: assert property (
    s_ack_drop |=> !out_r)
    else $error("acknowledge not dropped on clock rise");

  a_busy_low: assert property (
    conv_w && !ack_r && !start_w && !done_w && !reduce_w |=> !out_r)
    else $error("busy not shown low");

  a_done_high: assert property (
    done_w |=> state_r == sdadc_pkg::ST_READOUT && out_r && !osc_run_r)
    else $error("completion not signalled");

  a_shift_bit: assert property (
    shift_w |=> out_r == $past(word_r[15]) &&
                bit_cnt_r == $past(bit_cnt_r) + 5'h01)
    else $error("result bit not presented");

  a_no_reserved: assert property (
    done_w |=> word_r != `SDADC_WORD_RESERVED)
    else $error("reserved code produced");

  a_filter_hold: assert property (
    change_w |-> differ_w && $past(differ_w, 4))
    else $error("short clock pulse accepted");

  a_restart: assert property (
    state_r == sdadc_pkg::ST_READOUT && fall_w && bit_cnt_r == nbits_w
    |=> conv_w && bit_cnt_r == 5'h00)
    else $error("edge after last bit did not restart");

endmodule // sigma_delta_adc_two_wire_port

// >>> bench/sdadc_host_model.sv
/*
 * host model: drives the serial clock on its own 80 ns grid, reads data.
 * assumes the bench calls its tasks one at a time, hierarchically.
 */
`timescale 1ns/1ps

module sdadc_host_model #(
  parameter int HALF = 3
) (
  input  wire logic i_serial_result_out,
  output logic      o_serial_clk
);
  logic lclk;

  // link time base, phase unrelated to the core clock
  initial
  begin
    lclk = 1'b0;
    o_serial_clk = 1'b1; // clock rests high
    #13;
    forever #40 lclk = ~lclk;
  end

  // one fall then rise; data sampled high, low, high
  task automatic pulse(output logic [2:0] pat);
    pat[2] = i_serial_result_out;
    @(posedge lclk) o_serial_clk <= 1'b0;
    repeat (HALF) @(posedge lclk);
    pat[1] = i_serial_result_out;
    o_serial_clk <= 1'b1;
    repeat (HALF) @(posedge lclk);
    pat[0] = i_serial_result_out;
  endtask

  // no reading before data goes high, bounded
  task automatic wait_done(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 5000 && !ok; i++)
      @(posedge lclk) ok = i_serial_result_out;
  endtask

  // one bit per fall, taken while clock is low
  task automatic read(input int n, output logic [15:0] w);
    logic [2:0] p;
    w = 16'h0000;
    repeat (n)
    begin
      pulse(p);
      w = {w[14:0], p[1]};
    end
  endtask

  // lost host: pulse until 1-1-0 marks a start, bounded
  task automatic find_start(input int lim, output int n);
    logic [2:0] p;
    n = 0;
    p = 3'b000;
    while (n < lim && p != 3'b110)
    begin
      pulse(p);
      n++;
    end
  endtask

  // low pulse of 30 ns, shorter than the 50 ns filter width
  task automatic glitch;
    @(posedge lclk) o_serial_clk <= 1'b0;
    #30 o_serial_clk = 1'b1;
  endtask
endmodule // sdadc_host_model

// >>> bench/sigma_delta_adc_two_wire_port_test.sv
/*
 * self-checking bench of the two-wire converter port.
 * assumes shortened timing parameters; pulses of 240 ns trade margin
 * over the filter for a short run.
 */
`timescale 1ns/1ps

module sigma_delta_adc_two_wire_port_test;
  localparam int CONV = 16000;
  localparam int DIV  = 2;
  logic        i_core_clk;
  logic        i_rst;
  logic        i_serial_clk;
  logic [15:0] i_conv_word;
  logic        o_serial_result_out;
  logic        o_osc_run;
  logic [2:0]  o_reduction;
  int          mismatches;
  int          cmp_count;
  int          run_cycles = 0;

  sigma_delta_adc_two_wire_port #(
    .OSC_DIV(DIV), .CONV_TICKS(CONV), .WIN_TICKS(220), .FILT_CYCLES(5)
  ) DUT (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_serial_clk(i_serial_clk),
    .i_conv_word(i_conv_word), .o_serial_result_out(o_serial_result_out),
    .o_osc_run(o_osc_run), .o_reduction(o_reduction)
  );

  sdadc_host_model host (
    .i_serial_result_out(o_serial_result_out),
    .o_serial_clk(i_serial_clk)
  );

  // core clock
  initial
  begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  // length of the running oscillator, cleared by the start fall
  always @(posedge i_core_clk)
    if (o_osc_run)
      run_cycles <= run_cycles + 1;
    else if (!i_serial_clk)
      run_cycles <= 0;

  task automatic check(input logic [15:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // idle state and a rejected glitch
  task automatic idle_glitch;
    logic [15:0] got;
    got = {13'h0, o_serial_result_out, o_osc_run, o_reduction[0]};
    check(got, 16'h0004, "idle");
    check({13'h0, o_reduction}, 16'h0000, "idle count");
    host.glitch();
    repeat (30) @(posedge i_core_clk);
    got = {14'h0, o_serial_result_out, o_osc_run};
    check(got, 16'h0002, "glitch");
  endtask

  // start, some falls in the window, wait, read the shortened word
  task automatic conv_read(input logic [15:0] word, input int falls);
    logic [2:0]  pat;
    logic [15:0] got;
    logic [15:0] exp;
    logic [15:0] ack;
    logic        ok;
    int          r;
    int          t;
    r = (falls > 6) ? 6 : falls;
    exp = (word === 16'h8000) ? 16'h8001 : word;
    @(posedge i_core_clk) i_conv_word <= word;
    host.pulse(pat);
    got = {14'h0, pat[1:0]};
    check(got, 16'h0002, "start ack");
    check({15'h0, o_osc_run}, 16'h0001, "osc on");
    for (int i = 0; i < falls; i++)
    begin
      host.pulse(pat);
      ack = (i < 6) ? 16'h0002 : 16'h0000;
      check({13'h0, pat}, ack, "reduce");
    end
    check({13'h0, o_reduction}, 16'(r), "count");
    host.wait_done(ok);
    check({15'h0, ok}, 16'h0001, "done");
    if (!ok)
      give_verdict();
    else
    begin
      @(negedge i_core_clk);
      check({15'h0, o_osc_run}, 16'h0000, "asleep");
      t = (CONV >> r) * DIV;
      ok = run_cycles >= t - 6 && run_cycles <= t + 6;
      check({15'h0, ok}, 16'h0001, "conv time");
      host.read(16 - r, got);
      check(got, exp >> r, "word");
    end
  endtask

  // host loses track after a restart and hunts for the next start
  task automatic resync;
    logic [2:0] pat;
    int         n;
    logic       ok;
    @(posedge i_core_clk) i_conv_word <= 16'hffff;
    host.pulse(pat);
    host.find_start(64, n);
    ok = n >= 17 && n < 64;
    check({15'h0, ok}, 16'h0001, "resync");
    check({12'h0, o_osc_run, o_reduction}, 16'h0008, "hunted");
  endtask

  initial
  begin
    mismatches = 0;
    cmp_count = 0;
    i_rst = 1'b1;
    i_conv_word = 16'h0000;
    repeat (2) @(posedge i_core_clk);
    i_rst <= 1'b0;
    @(posedge i_core_clk);
    idle_glitch();
    conv_read(16'h7fff, 0);
    conv_read(16'h8000, 7);
    conv_read(16'hffff, 2);
    conv_read(16'h8001, 1);
    resync();
    give_verdict();
  end
endmodule // sigma_delta_adc_two_wire_port_test
